/* common/fjdb_pkg.sv */
// Package for the fall and jolt event debounce block.
// Assumes byte-wide register writes and one shared sample clock.
package fjdb_pkg;
    // Register addresses
    localparam logic [7:0] FALL_EVENT_CONTROL_ADDR = 8'h0b;
    localparam logic [7:0] JOLT_DEBOUNCE_CONTROL_ADDR = 8'h0c;
    // Reset values
    localparam logic [7:0] FALL_EVENT_CONTROL_RST = 8'h00;
    localparam logic [7:0] JOLT_DEBOUNCE_CONTROL_RST = 8'h00;
    // Field layout of fall_event_control
    localparam int FALL_MODE_BIT = 7;
    localparam int FALL_IRQ_ENABLE_BIT = 6;
    localparam int FALL_DEBOUNCE_LSB = 0;
    localparam int FALL_DEBOUNCE_W = 3;
    // Field layout of jolt_debounce_control
    localparam int JOLT_DEBOUNCE_LSB = 0;
    localparam int JOLT_DEBOUNCE_W = 6;
    // Fall method encodings
    localparam logic FALL_MODE_SUM = 1'b0;
    localparam logic FALL_MODE_PER_AXIS = 1'b1;
    // Counter widths: fall needs up to 8, jolt up to 63
    localparam int FALL_CNT_W = 4;
    localparam int JOLT_CNT_W = 6;
    // Sample width and the code of 0.5g at that width (a plain default)
    localparam int AXIS_W = 14;
    localparam int HALF_G_CODE = 2048;
endpackage : fjdb_pkg

/* rtl/fjdb_debounce.sv */
// Adjacent-sample run counter that fires once when a run reaches its target.
// Assumes i_tick marks one sample and i_target is at least one.
`timescale 1ns/1ps
`default_nettype none

module fjdb_debounce #(
    parameter int unsigned CW = 6
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_tick,
    input wire logic i_hit,
    input wire logic [CW-1:0] i_target,
    output logic o_fire
);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic fire_r;
    logic fire_nxt;
    logic [CW-1:0] cnt_inc;

    assign cnt_inc = CW'(cnt_r + 1'b1);

    always_comb begin
        cnt_nxt = cnt_r;
        fire_nxt = 1'b0;
        if (i_tick) begin
            if (!i_hit) begin
                cnt_nxt = '0;
            end else if (cnt_r < i_target) begin
                cnt_nxt = cnt_inc;
                // Fires only on reaching; a long run does not refire
                fire_nxt = (cnt_inc == i_target);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= '0;
            fire_r <= 1'b0;
        end else if (i_ce) begin
            cnt_r <= cnt_nxt;
            fire_r <= fire_nxt;
        end
    end

    assign o_fire = fire_r;
endmodule // fjdb_debounce

`default_nettype wire

/* rtl/fjdb_top.sv */
// Fall and jolt event qualification: write-only control, debounce, flags.
// Assumes samples, thresholds and raw jolt hits come from logic on i_clk.
`timescale 1ns/1ps
`default_nettype none

module fjdb_top #(
    parameter int unsigned AW = fjdb_pkg::AXIS_W,
    parameter int HALF_G = fjdb_pkg::HALF_G_CODE
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_sample_valid,
    input wire logic signed [AW-1:0] i_x,
    input wire logic signed [AW-1:0] i_y,
    input wire logic signed [AW-1:0] i_z,
    input wire logic signed [AW-1:0] i_fall_threshold,
    input wire logic [2:0] i_jolt_hit,
    input wire logic i_jolt_irq_enable_x,
    input wire logic i_jolt_irq_enable_y,
    input wire logic i_jolt_irq_enable_z,
    input wire logic i_fall_flag_clr,
    input wire logic i_jolt_flag_clr,
    output logic o_fall_mode,
    output logic o_fall_irq_enable,
    output logic [2:0] o_fall_debounce_count,
    output logic [5:0] o_jolt_debounce_count,
    output logic o_fall_event,
    output logic [2:0] o_jolt_event,
    output logic o_fall_detected_flag,
    output logic o_jolt_detected_flag,
    output logic o_fall_irq,
    output logic o_jolt_irq
);
    localparam int SW = AW + 3;
    localparam int FCW = fjdb_pkg::FALL_CNT_W;
    localparam int JCW = fjdb_pkg::JOLT_CNT_W;

    // Control registers
    logic [7:0] fall_ctrl_r;
    logic [7:0] fall_ctrl_nxt;
    logic [7:0] jolt_ctrl_r;
    logic [7:0] jolt_ctrl_nxt;

    always_comb begin
        fall_ctrl_nxt = fall_ctrl_r;
        jolt_ctrl_nxt = jolt_ctrl_r;
        if (i_reg_wr && (i_reg_addr == fjdb_pkg::FALL_EVENT_CONTROL_ADDR)) begin
            fall_ctrl_nxt = i_reg_wdata;
            // Reserved bits are kept at zero
            fall_ctrl_nxt[5:3] = 3'h0;
        end
        if (i_reg_wr && (i_reg_addr == fjdb_pkg::JOLT_DEBOUNCE_CONTROL_ADDR)) begin
            jolt_ctrl_nxt = {2'h0, i_reg_wdata[5:0]};
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fall_ctrl_r <= fjdb_pkg::FALL_EVENT_CONTROL_RST;
            jolt_ctrl_r <= fjdb_pkg::JOLT_DEBOUNCE_CONTROL_RST;
        end else if (i_ce) begin
            fall_ctrl_r <= fall_ctrl_nxt;
            jolt_ctrl_r <= jolt_ctrl_nxt;
        end
    end

    logic fall_mode;
    logic fall_irq_en;
    logic [fjdb_pkg::FALL_DEBOUNCE_W-1:0] fall_db;
    logic [fjdb_pkg::JOLT_DEBOUNCE_W-1:0] jolt_db;

    assign fall_mode = fall_ctrl_r[fjdb_pkg::FALL_MODE_BIT];
    assign fall_irq_en = fall_ctrl_r[fjdb_pkg::FALL_IRQ_ENABLE_BIT];
    assign fall_db = fall_ctrl_r[fjdb_pkg::FALL_DEBOUNCE_LSB +: fjdb_pkg::FALL_DEBOUNCE_W];
    assign jolt_db = jolt_ctrl_r[fjdb_pkg::JOLT_DEBOUNCE_LSB +: fjdb_pkg::JOLT_DEBOUNCE_W];

    // Debounce targets
    logic [FCW-1:0] fall_target;
    logic [JCW-1:0] jolt_target;

    assign fall_target = FCW'({1'b0, fall_db} + 4'h1);
    assign jolt_target = (jolt_db == '0) ? JCW'(1) : jolt_db;

    // Fall condition, widened so sums and signed levels never overflow
    logic signed [SW-1:0] mag_x;
    logic signed [SW-1:0] mag_y;
    logic signed [SW-1:0] mag_z;
    logic signed [SW-1:0] mag_sum;
    logic signed [SW-1:0] fall_level;
    logic fall_hit;

    function automatic logic signed [SW-1:0] fjdb_abs(input logic signed [AW-1:0] v);
        logic signed [SW-1:0] w;
        w = SW'(v);
        fjdb_abs = (w < 0) ? -w : w;
    endfunction

    always_comb begin
        mag_x = fjdb_abs(i_x);
        mag_y = fjdb_abs(i_y);
        mag_z = fjdb_abs(i_z);
        mag_sum = mag_x + mag_y + mag_z;
        fall_level = SW'(HALF_G) + SW'(i_fall_threshold);
        if (fall_mode == fjdb_pkg::FALL_MODE_SUM) begin
            fall_hit = (mag_sum < fall_level);
        end else begin
            fall_hit = (mag_x < fall_level) && (mag_y < fall_level)
                && (mag_z < fall_level);
        end
    end

    // Debounce counters: one for fall, one per jolt axis
    logic fall_fire;
    logic [2:0] jolt_fire;

    fjdb_debounce #(
        .CW(FCW)
    ) u_fall_db (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_tick(i_sample_valid),
        .i_hit(fall_hit),
        .i_target(fall_target),
        .o_fire(fall_fire)
    );

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_jolt
            fjdb_debounce #(
                .CW(JCW)
            ) u_jolt_db (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_ce(i_ce),
                .i_tick(i_sample_valid),
                .i_hit(i_jolt_hit[g]),
                .i_target(jolt_target),
                .o_fire(jolt_fire[g])
            );
        end
    endgenerate

    // Flags and interrupt pulses
    logic [2:0] jolt_en;
    logic jolt_qual;

    assign jolt_en = {i_jolt_irq_enable_z, i_jolt_irq_enable_y, i_jolt_irq_enable_x};
    assign jolt_qual = |(jolt_fire & jolt_en);

    logic fall_flag_r;
    logic fall_flag_nxt;
    logic jolt_flag_r;
    logic jolt_flag_nxt;
    logic fall_irq_r;
    logic fall_irq_nxt;
    logic jolt_irq_r;
    logic jolt_irq_nxt;
    logic fall_evt_r;
    logic [2:0] jolt_evt_r;

    always_comb begin
        // Set beats clear so an event in the clearing cycle survives
        fall_flag_nxt = fall_fire | (fall_flag_r & ~i_fall_flag_clr);
        jolt_flag_nxt = jolt_qual | (jolt_flag_r & ~i_jolt_flag_clr);
        fall_irq_nxt = fall_fire & fall_irq_en;
        jolt_irq_nxt = jolt_qual;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fall_flag_r <= 1'b0;
            jolt_flag_r <= 1'b0;
            fall_irq_r <= 1'b0;
            jolt_irq_r <= 1'b0;
            fall_evt_r <= 1'b0;
            jolt_evt_r <= 3'h0;
        end else if (i_ce) begin
            fall_flag_r <= fall_flag_nxt;
            jolt_flag_r <= jolt_flag_nxt;
            fall_irq_r <= fall_irq_nxt;
            jolt_irq_r <= jolt_irq_nxt;
            fall_evt_r <= fall_fire;
            jolt_evt_r <= jolt_fire;
        end
    end

    assign o_fall_mode = fall_mode;
    assign o_fall_irq_enable = fall_irq_en;
    assign o_fall_debounce_count = fall_db;
    assign o_jolt_debounce_count = jolt_db;
    assign o_fall_event = fall_evt_r;
    assign o_jolt_event = jolt_evt_r;
    assign o_fall_detected_flag = fall_flag_r;
    assign o_jolt_detected_flag = jolt_flag_r;
    assign o_fall_irq = fall_irq_r;
    assign o_jolt_irq = jolt_irq_r;
endmodule // fjdb_top

`default_nettype wire

/* verification/fjdb_host_model.sv */
// Host model: writes control registers one byte at a time.
// Assumes callers enter shortly after a rising edge of i_clk.
`timescale 1ns/1ps
`default_nettype none
module fjdb_host_model (
    input wire logic i_clk,
    output logic o_wr,
    output logic [7:0] o_addr,
    output logic [7:0] o_data
);
    initial begin
        o_wr = 1'b0;
        o_addr = 8'h00;
        o_data = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        o_wr = 1'b1;
        o_addr = a;
        o_data = d;
        @(posedge i_clk) #1 o_wr = 1'b0;
        // Released lines carry junk so a stale byte cannot pass
        o_addr = ~a;
        o_data = ~d;
        // One idle edge so a following write never retoggles the strobe at once
        @(posedge i_clk) #1;
    endtask
endmodule // fjdb_host_model
`default_nettype wire

/* verification/fjdb_monitor.sv */
// Checker of the fjdb_top port behaviour, bound to every instance.
// Assumes enables are judged as they stood when the internal fire was registered.
`timescale 1ns/1ps
`default_nettype none
module fjdb_monitor (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_sample_valid,
    input wire logic [2:0] i_jolt_hit,
    input wire logic i_jolt_irq_enable_x,
    input wire logic i_jolt_irq_enable_y,
    input wire logic i_jolt_irq_enable_z,
    input wire logic o_fall_mode,
    input wire logic o_fall_irq_enable,
    input wire logic [2:0] o_fall_debounce_count,
    input wire logic [5:0] o_jolt_debounce_count,
    input wire logic o_fall_event,
    input wire logic [2:0] o_jolt_event,
    input wire logic o_fall_detected_flag,
    input wire logic o_jolt_detected_flag,
    input wire logic o_fall_irq,
    input wire logic o_jolt_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_fall_reg_write: assert property (i_ce && i_reg_wr && i_reg_addr == 8'h0b |=>
        {o_fall_mode, o_fall_irq_enable} == $past(i_reg_wdata[7:6])
        && o_fall_debounce_count == $past(i_reg_wdata[2:0])) else $error("fall control write lost");
    a_jolt_reg_write: assert property (i_ce && i_reg_wr && i_reg_addr == 8'h0c |=>
        o_jolt_debounce_count == $past(i_reg_wdata[5:0])) else $error("jolt control write lost");
    a_fall_from_sample: assert property (o_fall_event |-> $past(i_sample_valid, 2))
        else $error("fall event without a sample");
    a_fall_single_pulse: assert property (o_fall_event |=> !o_fall_event)
        else $error("fall event refired");
    a_fall_flag_set: assert property (o_fall_event |-> o_fall_detected_flag)
        else $error("fall flag not set");
    a_fall_irq_cause: assert property (o_fall_irq |->
        o_fall_event && $past(o_fall_irq_enable))
        else $error("fall irq without enabled event");
    a_jolt_from_hit: assert property (o_jolt_event[0] |-> $past(i_jolt_hit[0], 2))
        else $error("jolt event without hit");
    a_jolt_irq_cause: assert property (o_jolt_irq |-> |(o_jolt_event &
        {$past(i_jolt_irq_enable_z), $past(i_jolt_irq_enable_y),
        $past(i_jolt_irq_enable_x)}))
        else $error("jolt irq without enabled axis");
    a_jolt_flag_gate: assert property ($rose(o_jolt_detected_flag) |-> o_jolt_irq)
        else $error("jolt flag set by disabled axis");
    c_fall_irq: cover property (o_fall_irq);
    c_jolt_irq: cover property (o_jolt_irq);
    c_jolt_quiet: cover property (|o_jolt_event && !o_jolt_irq);
endmodule // fjdb_monitor
bind fjdb_top fjdb_monitor fjdb_monitor_inst (.i_clk, .i_rst_n, .i_ce, .i_reg_wr, .i_reg_addr,
    .i_reg_wdata, .i_sample_valid, .i_jolt_hit, .i_jolt_irq_enable_x, .i_jolt_irq_enable_y,
    .i_jolt_irq_enable_z, .o_fall_mode, .o_fall_irq_enable, .o_fall_debounce_count,
    .o_jolt_debounce_count, .o_fall_event, .o_jolt_event, .o_fall_detected_flag,
    .o_jolt_detected_flag, .o_fall_irq, .o_jolt_irq);
`default_nettype wire

/* verification/tb_fjdb_top.sv */
// Self-checking bench: writes control bytes, streams samples, checks events.
// Assumes the host model drives the write port and i_ce stays high.
`timescale 1ns/1ps
`default_nettype none
module tb_fjdb_top;
    logic clk, rst_n, sv, fclr, jclr, ex, ey, ez, wr, fm, fie, fe, ff, jf, fi, ji;
    logic [7:0] ad, wd;
    logic signed [13:0] x, y, z, thr;
    logic [2:0] jh, je, fdb;
    logic [5:0] jdb;
    int n_fail, n_compared, nf, nj;
    fjdb_host_model fjdb_host_model_inst (.i_clk(clk), .o_wr(wr), .o_addr(ad), .o_data(wd));
    fjdb_top fjdb_top_inst (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_reg_wr(wr),
        .i_reg_addr(ad), .i_reg_wdata(wd), .i_sample_valid(sv), .i_x(x), .i_y(y), .i_z(z),
        .i_fall_threshold(thr), .i_jolt_hit(jh), .i_jolt_irq_enable_x(ex),
        .i_jolt_irq_enable_y(ey), .i_jolt_irq_enable_z(ez), .i_fall_flag_clr(fclr),
        .i_jolt_flag_clr(jclr), .o_fall_mode(fm), .o_fall_irq_enable(fie),
        .o_fall_debounce_count(fdb), .o_jolt_debounce_count(jdb), .o_fall_event(fe),
        .o_jolt_event(je), .o_fall_detected_flag(ff), .o_jolt_detected_flag(jf),
        .o_fall_irq(fi), .o_jolt_irq(ji));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic wrap_up;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // n samples; event and irq pulses stand only in the cycle after the second edge of each sample
    task automatic smp(input int n, input logic signed [13:0] a, b, c, input logic [2:0] h);
        nf = 0;
        nj = 0;
        repeat (n) begin
            x = a; y = b; z = c; jh = h; sv = 1'b1;
            @(posedge clk) #1 sv = 1'b0;
            @(posedge clk);
            #1 nf += (fe === 1'b1);
            nj += (je !== 3'b000);
        end
    endtask
    task automatic clr;
        fclr = 1'b1;
        jclr = 1'b1;
        @(posedge clk) #1 fclr = 1'b0;
        jclr = 1'b0;
    endtask
    initial begin
        #20us n_fail++;
        wrap_up;
    end
    initial begin
        n_fail = 0; n_compared = 0; sv = 0; fclr = 0; jclr = 0; {ez, ey, ex} = 3'b001;
        x = 0; y = 0; z = 0; jh = 0; thr = 0; rst_n = 0;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        chk("regs", 8'h00, {fm, fie, fdb, 3'(jdb)});
        smp(1, 0, 0, 0, 3'b001);
        chk("jolt", 8'h07, {je, ji, jf});
        chk("fall", 8'h06, {fe, ff, fi});
        clr();
        fjdb_host_model_inst.wr(8'h0b, 8'h41);
        smp(1, 100, 100, 100, 0);
        smp(1, -1500, 1500, 1500, 0);
        smp(2, 100, 100, 100, 0);
        chk("fall", 8'h07, {fe, ff, fi});
        chk("nfall", 8'h01, 8'(nf));
        fjdb_host_model_inst.wr(8'h0b, 8'h80);
        clr();
        thr = -500;
        // Break the saturated run first, or the lowered target never fires
        smp(1, 2048, 0, 0, 0);
        smp(1, -1500, 1500, 1500, 0);
        chk("axis", 8'h06, {fe, ff, fi});
        thr = -600;
        smp(1, -1500, 1500, 1500, 0);
        chk("axis", 8'h00, 8'(fe));
        thr = 0;
        fjdb_host_model_inst.wr(8'h0b, 8'h00);
        smp(1, 2048, 0, 0, 0);
        chk("sum", 8'h00, 8'(fe));
        smp(1, 2047, 0, 0, 0);
        chk("sum", 8'h01, 8'(fe));
        fjdb_host_model_inst.wr(8'h0d, 8'hff);
        chk("unmap", 8'h00, {fm, fie, fdb, 3'(jdb)});
        fjdb_host_model_inst.wr(8'h0b, 8'h07);
        smp(1, 2048, 0, 0, 0);
        smp(7, 0, 0, 0, 0);
        chk("f8", 8'h00, 8'(nf));
        smp(1, 0, 0, 0, 0);
        chk("f8", 8'h01, 8'(fe));
        fjdb_host_model_inst.wr(8'h0c, 8'h03);
        clr();
        smp(2, 2048, 0, 0, 3'b011);
        chk("j3", 8'h00, 8'(nj));
        smp(1, 2048, 0, 0, 3'b011);
        chk("j3", 8'h0f, {je, ji, jf});
        smp(1, 2048, 0, 0, 0);
        clr();
        smp(3, 2048, 0, 0, 3'b010);
        chk("jy", 8'h08, {je, ji, jf});
        fjdb_host_model_inst.wr(8'h0c, 8'h3f);
        {ez, ey, ex} = 3'b100;
        smp(62, 2048, 0, 0, 3'b100);
        chk("j63", 8'h00, 8'(nj));
        smp(1, 2048, 0, 0, 3'b100);
        chk("j63", 8'h13, {je, ji, jf});
        wrap_up();
    end
endmodule // tb_fjdb_top
`default_nettype wire
